// ===== hdl/setting_error_checker_defs.vh
// constants for the setting error checker
`ifndef SETTING_ERROR_CHECKER_DEFS_VH
`define SETTING_ERROR_CHECKER_DEFS_VH

// register offsets
`define OFS_ERR_WORD   8'h00
`define OFS_ERR_RESET  8'h01
`define OFS_STATUS     8'h02
`define OFS_CONFIRM    8'h03
`define OFS_CONT_FLAG  8'h10
`define OFS_PRM_BASE   8'h20

// parameter entry indices
`define IDX_LIM_UU     3'h0
`define IDX_LIM_UL     3'h1
`define IDX_LIM_LU     3'h2
`define IDX_LIM_LL     3'h3
`define IDX_CYC_CTRL   3'h4
`define IDX_CYC_HEAT   3'h5
`define IDX_CYC_COOL   3'h6
`define IDX_SETPOINT   3'h7
`define NUM_LIMITS     8'h04

// defaults of the parameter entries
`define DEF_LIM_UU     16'h0514
`define DEF_LIM_UL     16'h04b0
`define DEF_LIM_LU     16'h0032
`define DEF_LIM_LL     16'h0000
`define DEF_CYC        16'h001e
`define DEF_SETPOINT   16'h0000

// error types and fields
`define ET_ORDER       4'h8
`define ET_DISC        4'he
`define ET_SWITCH      4'hf
`define ERR_TYPE_W     4
`define ERR_ADDR_W     12
`define DISC_SHIFT     4

// switch setting ranges
`define SW_MODE_MAX    4'h5
`define SW_UNIT_MAX    2'h1
`define SW_SAMP_MAX    2'h1

// status bits
`define ST_BIT_OPER    0
`define ST_BIT_PEND    1
`define ST_BIT_HALT    2

`endif

// ===== hdl/limit_order_check.v
// alarm limit ordering check with lowest faulting entry
`timescale 1ns/1ps
`include "setting_error_checker_defs.vh"
module limit_order_check #(
    parameter DW = 16
) (
    // limits, high to low
    input  wire [DW-1:0] limUu,
    input  wire [DW-1:0] limUl,
    input  wire [DW-1:0] limLu,
    input  wire [DW-1:0] limLl,
    // result
    output wire          orderErr,
    output reg  [2:0]    faultIdx
);
    wire badA = limUu < limUl;
    wire badB = limUl < limLu;
    wire badC = limLu < limLl;

    assign orderErr = badA | badB | badC;

    // lowest entry of the first failing pair wins
    always @* begin
        if (badA)
            faultIdx = `IDX_LIM_UU;
        else if (badB)
            faultIdx = `IDX_LIM_UL;
        else
            faultIdx = `IDX_LIM_LU;
    end
endmodule

// ===== hdl/setting_error_checker.v
// setting error checker: limit ordering, switch discrepancy, switch range
`timescale 1ns/1ps
`include "setting_error_checker_defs.vh"
module setting_error_checker #(
    parameter AW   = 8,
    parameter DW   = 16,
    parameter NPRM = 8
) (
    // clock and reset
    input  wire            core_clk,
    input  wire            arst_n,
    // register port
    input  wire [AW-1:0]   regAddr,
    input  wire [DW-1:0]   regWrData,
    input  wire            regWr,
    input  wire            regRd,
    output reg  [DW-1:0]   regRdData,
    // switch settings and their non-volatile copies
    input  wire [3:0]      swCtrlMode,
    input  wire [1:0]      swCycleUnit,
    input  wire [1:0]      swSampling,
    input  wire [3:0]      nvCtrlMode,
    input  wire [1:0]      nvCycleUnit,
    input  wire [1:0]      nvSampling,
    // mode handshake
    input  wire            modeRequestOutput,
    output reg             modeStateInput,
    output wire            operating,
    // indicators
    output reg             runLed,
    output reg             errLed,
    // limits in effect for control
    output reg  [DW-1:0]   ctrlLimUu,
    output reg  [DW-1:0]   ctrlLimUl,
    output reg  [DW-1:0]   ctrlLimLu,
    output reg  [DW-1:0]   ctrlLimLl
);
    localparam ST_CHECK = 2'b00;
    localparam ST_PEND  = 2'b01;
    localparam ST_RUN   = 2'b10;
    localparam ST_HALT  = 2'b11;

    reg  [1:0]      state_reg;
    reg  [1:0]      state_next;
    reg  [DW-1:0]   errWord_reg;
    reg  [DW-1:0]   errWord_next;
    reg             pidContinueFlag_reg;
    reg             reqPrev_reg;
    reg             contLatch_reg;
    reg             contLatch_next;
    reg             chkReq_reg;
    reg             restoreAll;
    reg             restoreBk;
    reg  [DW-1:0]   rdMux;
    wire [2:0]      discBits;
    wire            swBad;
    wire [AW-1:0]   prmOff;
    wire            prmHit;
    wire            prmWr;
    wire            limWr;
    wire            confirmWr;
    wire            errResetWr;
    wire [NPRM*DW-1:0] prmFlat;
    wire            orderErr;
    wire [2:0]      faultIdx;
    wire [AW-1:0]   faultAddr;
    wire            stRun;
    wire            stPend;
    wire            stHalt;
    wire            contFlagWr;
    wire            reqFell;
    wire [DW-1:0]   orderWord;
    wire [DW-1:0]   discWord;
    wire [DW-1:0]   switchWord;
    reg  [DW-1:0]   statusWord;

    // parameter entries and their default values
    function [DW-1:0] prmDefault;
        input integer idx;
        begin
            case (idx)
                0:       prmDefault = `DEF_LIM_UU;
                1:       prmDefault = `DEF_LIM_UL;
                2:       prmDefault = `DEF_LIM_LU;
                3:       prmDefault = `DEF_LIM_LL;
                4:       prmDefault = `DEF_CYC;
                5:       prmDefault = `DEF_CYC;
                6:       prmDefault = `DEF_CYC;
                default: prmDefault = `DEF_SETPOINT;
            endcase
        end
    endfunction

    function isCycle;
        input integer idx;
        begin
            isCycle = (idx == `IDX_CYC_CTRL) || (idx == `IDX_CYC_HEAT) ||
                      (idx == `IDX_CYC_COOL);
        end
    endfunction

    // register decode
    assign prmOff     = regAddr - `OFS_PRM_BASE;
    assign prmHit     = (regAddr >= `OFS_PRM_BASE) && (prmOff < NPRM);
    // set values only take register writes while running, never while a mismatch waits
    assign prmWr      = regWr && prmHit && stRun;
    assign limWr      = prmWr && (prmOff < `NUM_LIMITS);
    assign confirmWr  = regWr && (regAddr == `OFS_CONFIRM) && stPend;
    assign errResetWr = regWr && (regAddr == `OFS_ERR_RESET) && !stHalt;
    // a halted module takes no flag write either
    assign contFlagWr = regWr && (regAddr == `OFS_CONT_FLAG) && !stHalt;
    assign stRun      = (state_reg == ST_RUN);
    assign stPend     = (state_reg == ST_PEND);
    assign stHalt     = (state_reg == ST_HALT);

    // switch checks, only evaluated once after reset
    assign swBad = (swCtrlMode > `SW_MODE_MAX) || (swCycleUnit > `SW_UNIT_MAX) ||
                   (swSampling > `SW_SAMP_MAX);
    assign discBits = {swSampling != nvSampling,
                       swCycleUnit != nvCycleUnit,
                       swCtrlMode != nvCtrlMode};

    always @* begin
        restoreAll = 1'b0;
        restoreBk  = 1'b0;
        if (state_reg == ST_CHECK && !swBad) begin
            restoreAll = discBits[0] | discBits[2];
            restoreBk  = discBits[1] & ~restoreAll;
        end
    end

    // parameter store and backup copy, one slot per entry
    genvar gi;
    generate
        for (gi = 0; gi < NPRM; gi = gi + 1) begin : g_prm
            // per-entry constants keep the reset branch to plain values
            localparam [DW-1:0] DEF_VAL = prmDefault(gi);
            localparam          IS_CYC  = isCycle(gi);
            reg [DW-1:0] val_reg;
            reg [DW-1:0] bk_reg;
            // backup resets to defaults; the real copy lives in non-volatile memory
            always @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    val_reg <= DEF_VAL;
                    bk_reg  <= DEF_VAL;
                end else begin
                    if (restoreAll)
                        val_reg <= DEF_VAL;
                    else if (restoreBk)
                        val_reg <= IS_CYC ? DEF_VAL : bk_reg;
                    else if (prmWr && prmOff == gi)
                        val_reg <= regWrData;
                    if (confirmWr)
                        bk_reg <= val_reg;
                end
            end
            assign prmFlat[gi*DW +: DW] = val_reg;
        end
    endgenerate

    limit_order_check #(
        .DW(DW)
    ) u_order (
        .limUu   (prmFlat[`IDX_LIM_UU*DW +: DW]),
        .limUl   (prmFlat[`IDX_LIM_UL*DW +: DW]),
        .limLu   (prmFlat[`IDX_LIM_LU*DW +: DW]),
        .limLl   (prmFlat[`IDX_LIM_LL*DW +: DW]),
        .orderErr(orderErr),
        .faultIdx(faultIdx)
    );

    assign faultAddr = `OFS_PRM_BASE + {{(AW-3){1'b0}}, faultIdx};

    // error words: buffer address or mismatch bits above the type digit
    assign orderWord  = {{(DW-AW-`ERR_TYPE_W){1'b0}}, faultAddr, `ET_ORDER};
    assign discWord   = ({{(DW-3){1'b0}}, discBits} << `DISC_SHIFT) |
                        {{(DW-`ERR_TYPE_W){1'b0}}, `ET_DISC};
    assign switchWord = {{(DW-`ERR_TYPE_W){1'b0}}, `ET_SWITCH};

    // state and error word
    always @* begin
        state_next   = state_reg;
        errWord_next = errWord_reg;
        // clear first so that a fresh error in the same cycle wins
        if (errResetWr)
            errWord_next = {DW{1'b0}};
        case (state_reg)
            ST_CHECK: begin
                if (swBad) begin
                    state_next   = ST_HALT;
                    errWord_next = switchWord;
                end else if (|discBits) begin
                    state_next   = ST_PEND;
                    errWord_next = discWord;
                end else begin
                    state_next = ST_RUN;
                end
            end
            ST_PEND: begin
                if (confirmWr)
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (chkReq_reg && orderErr)
                    errWord_next = orderWord;
            end
            default: begin
                state_next = ST_HALT;
            end
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= ST_CHECK;
            errWord_reg <= {DW{1'b0}};
        end else begin
            state_reg   <= state_next;
            errWord_reg <= errWord_next;
        end
    end

    // limits in effect follow the store only when the ordering holds
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            chkReq_reg <= 1'b0;
            ctrlLimUu  <= `DEF_LIM_UU;
            ctrlLimUl  <= `DEF_LIM_UL;
            ctrlLimLu  <= `DEF_LIM_LU;
            ctrlLimLl  <= `DEF_LIM_LL;
        end else begin
            chkReq_reg <= limWr | restoreAll | restoreBk;
            if (chkReq_reg && !orderErr) begin
                ctrlLimUu <= prmFlat[`IDX_LIM_UU*DW +: DW];
                ctrlLimUl <= prmFlat[`IDX_LIM_UL*DW +: DW];
                ctrlLimLu <= prmFlat[`IDX_LIM_LU*DW +: DW];
                ctrlLimLl <= prmFlat[`IDX_LIM_LL*DW +: DW];
            end
        end
    end

    // operation mode tracking
    // the latch keeps operation going after the request drops with the flag set
    assign reqFell = reqPrev_reg && !modeRequestOutput;

    always @* begin
        contLatch_next = contLatch_reg;
        if (!pidContinueFlag_reg || modeRequestOutput)
            contLatch_next = 1'b0;
        else if (reqFell)
            contLatch_next = 1'b1;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pidContinueFlag_reg <= 1'b0;
            reqPrev_reg         <= 1'b0;
            contLatch_reg       <= 1'b0;
            modeStateInput      <= 1'b0;
            runLed              <= 1'b0;
            errLed              <= 1'b0;
        end else begin
            if (contFlagWr)
                pidContinueFlag_reg <= regWrData[0];
            reqPrev_reg    <= modeRequestOutput;
            contLatch_reg  <= contLatch_next;
            modeStateInput <= modeRequestOutput && (state_next == ST_RUN);
            runLed         <= (state_next != ST_HALT);
            errLed         <= (state_next == ST_HALT);
        end
    end

    // a halted module only answers reads, so it is never in operation
    assign operating = (state_reg != ST_HALT) &&
                       (modeRequestOutput || modeStateInput || contLatch_reg);

    // status bits for the controller; unused bits read as zero
    always @* begin
        statusWord               = {DW{1'b0}};
        statusWord[`ST_BIT_OPER] = operating;
        statusWord[`ST_BIT_PEND] = stPend;
        statusWord[`ST_BIT_HALT] = stHalt;
    end

    // read path
    always @* begin
        rdMux = {DW{1'b0}};
        if (prmHit) begin
            rdMux = prmFlat[prmOff[2:0]*DW +: DW];
        end else begin
            case (regAddr)
                `OFS_ERR_WORD:  rdMux = errWord_reg;
                `OFS_CONT_FLAG: rdMux = {{(DW-1){1'b0}}, pidContinueFlag_reg};
                `OFS_STATUS:    rdMux = statusWord;
                default:        rdMux = {DW{1'b0}};
            endcase
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            regRdData <= {DW{1'b0}};
        else
            regRdData <= regRd ? rdMux : {DW{1'b0}};
    end
endmodule

// ===== test/setting_error_checker_assertions.sv
// port assertions for the setting error checker
`timescale 1ns/1ps
module setting_error_checker_assertions #(
    parameter DW = 16
) (
    // clock and reset
    input wire          core_clk,
    input wire          arst_n,
    // register port
    input wire          regRd,
    input wire [DW-1:0] regRdData,
    // mode and indicators
    input wire          modeRequestOutput,
    input wire          modeStateInput,
    input wire          operating,
    input wire          runLed,
    input wire          errLed,
    // limits in effect
    input wire [DW-1:0] ctrlLimUu,
    input wire [DW-1:0] ctrlLimUl,
    input wire [DW-1:0] ctrlLimLu,
    input wire [DW-1:0] ctrlLimLl
);
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    led_excl_a: assert property (errLed |-> !runLed)
        else $error("run and error indicators on together");
    halt_quiet_a: assert property (errLed |-> !operating && !modeStateInput)
        else $error("halted module still operating");
    led_steady_a: assert property (!$fell(runLed) && !$fell(errLed))
        else $error("indicator changed after start");
    state_follow_a: assert property (modeStateInput |-> $past(modeRequestOutput))
        else $error("mode status without earlier request");
    req_oper_a: assert property (modeRequestOutput && runLed |-> operating)
        else $error("request high but not operating");
    state_oper_a: assert property (modeStateInput |-> operating)
        else $error("mode status high but not operating");
    rd_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data outside its cycle");
    lim_order_a: assert property (ctrlLimUu >= ctrlLimUl && ctrlLimUl >= ctrlLimLu
        && ctrlLimLu >= ctrlLimLl) else $error("control limits out of order");
    cover property (errLed);
    cover property (operating && !modeRequestOutput);
    cover property (regRd ##1 regRdData != 16'h0000);
endmodule

bind setting_error_checker setting_error_checker_assertions #(.DW(DW)) i_chk (
    .core_clk, .arst_n, .regRd, .regRdData, .modeRequestOutput, .modeStateInput,
    .operating, .runLed, .errLed, .ctrlLimUu, .ctrlLimUl, .ctrlLimLu, .ctrlLimLl);

// ===== test/cpu_model.sv
// behavioural controller cpu on the register port and mode request
`timescale 1ns/1ps
module cpu_model (
    // clock
    input  wire        core_clk,
    // register port
    output reg  [7:0]  regAddr,
    output reg  [15:0] regWrData,
    output reg         regWr,
    output reg         regRd,
    input  wire [15:0] regRdData,
    // mode request
    output reg         modeRequestOutput
);
    initial begin
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        modeRequestOutput = 1'b0;
    end
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            regAddr <= a;
            regWrData <= d;
            regWr <= 1'b1;
            @(posedge core_clk);
            regWr <= 1'b0;
            // stale data inverted so a late sample cannot pass
            regWrData <= ~d;
        end
    endtask
    task rd(input [7:0] a, output [15:0] d);
        begin
            @(posedge core_clk);
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge core_clk);
            regRd <= 1'b0;
            #1;
            d = regRdData;
        end
    endtask
    task mode(input v);
        begin
            @(posedge core_clk);
            modeRequestOutput <= v;
        end
    endtask
endmodule

// ===== test/setting_error_checker_tb_top.sv
// self-checking bench for the setting error checker
`timescale 1ns/1ps
module setting_error_checker_tb_top;
    reg         core_clk;
    reg         arst_n;
    reg  [3:0]  swCtrlMode, nvCtrlMode;
    reg  [1:0]  swCycleUnit, swSampling, nvCycleUnit, nvSampling;
    wire [7:0]  regAddr;
    wire [15:0] regWrData, regRdData, ctrlLimUu, ctrlLimUl, ctrlLimLu, ctrlLimLl;
    wire        regWr, regRd, modeRequestOutput, modeStateInput, operating, runLed, errLed;
    integer     n_fail, comparisons, i;
    reg  [15:0] got;
    reg  [24:0] rows [0:18];
    setting_error_checker i_dut (.core_clk, .arst_n, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .swCtrlMode, .swCycleUnit, .swSampling, .nvCtrlMode, .nvCycleUnit,
        .nvSampling, .modeRequestOutput, .modeStateInput, .operating, .runLed, .errLed,
        .ctrlLimUu, .ctrlLimUl, .ctrlLimLu, .ctrlLimLl);
    cpu_model i_cpu (.core_clk, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .modeRequestOutput);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk16(input [15:0] e, input [15:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: expected %h got %h", $time, e, g);
            end
        end
    endtask
    task chk1(input e, input g);
        begin
            chk16({15'h0000, e}, {15'h0000, g});
        end
    endtask
    task chkRd(input [7:0] a, input [15:0] e);
        begin
            i_cpu.rd(a, got);
            chk16(e, got);
        end
    endtask
    task dorst(input [3:0] sm, input [1:0] su, input [1:0] ss, input [3:0] nm,
               input [1:0] nu, input [1:0] ns);
        begin
            @(posedge core_clk);
            arst_n <= 1'b0;
            {swCtrlMode, swCycleUnit, swSampling} <= {sm, su, ss};
            {nvCtrlMode, nvCycleUnit, nvSampling} <= {nm, nu, ns};
            repeat (12) @(posedge core_clk);
            arst_n <= 1'b1;
            repeat (2) @(posedge core_clk);
            #1;
        end
    endtask
    initial begin
        // a hang is cut short here
        repeat (20000) @(posedge core_clk);
        n_fail = n_fail + 1;
        conclude;
    end
    initial begin
        n_fail = 0;
        comparisons = 0;
        arst_n = 1'b0;
        {swCtrlMode, swCycleUnit, swSampling} = 8'h10;
        {nvCtrlMode, nvCycleUnit, nvSampling} = 8'h10;
        rows[0] = {1'b0, 8'h00, 16'h0000};
        rows[1] = {1'b1, 8'h21, 16'h0600};
        rows[2] = {1'b0, 8'h00, 16'h0208};
        rows[3] = {1'b0, 8'h21, 16'h0600};
        rows[4] = {1'b1, 8'h21, 16'h04b0};
        rows[5] = {1'b0, 8'h00, 16'h0208};
        rows[6] = {1'b1, 8'h01, 16'h0000};
        rows[7] = {1'b1, 8'h22, 16'h0500};
        rows[8] = {1'b0, 8'h00, 16'h0218};
        rows[9] = {1'b1, 8'h22, 16'h0032};
        rows[10] = {1'b1, 8'h01, 16'h0000};
        rows[11] = {1'b1, 8'h23, 16'h0032};
        rows[12] = {1'b0, 8'h00, 16'h0000};
        rows[13] = {1'b1, 8'h23, 16'h0040};
        rows[14] = {1'b0, 8'h00, 16'h0228};
        rows[15] = {1'b1, 8'h23, 16'h0000};
        rows[16] = {1'b1, 8'h10, 16'h0001};
        rows[17] = {1'b0, 8'h05, 16'h0000};
        rows[18] = {1'b0, 8'h10, 16'h0001};
        dorst(4'h1, 2'h0, 2'h0, 4'h1, 2'h0, 2'h0);
        chk1(1'b1, runLed);
        chk1(1'b0, errLed);
        for (i = 0; i < 19; i = i + 1) begin
            if (rows[i][24])
                i_cpu.wr(rows[i][23:16], rows[i][15:0]);
            else
                chkRd(rows[i][23:16], rows[i][15:0]);
        end
        i_cpu.wr(8'h01, 16'h0000);
        i_cpu.wr(8'h21, 16'h0400);
        @(posedge core_clk);
        #1;
        chk16(16'h0400, ctrlLimUl);
        i_cpu.wr(8'h21, 16'h0600);
        repeat (2) @(posedge core_clk);
        #1;
        chk16(16'h0400, ctrlLimUl);
        i_cpu.wr(8'h20, 16'h0700);
        @(posedge core_clk);
        #1;
        chk16(16'h0700, ctrlLimUu);
        chk16(16'h0600, ctrlLimUl);
        chk16(16'h0032, ctrlLimLu);
        chk16(16'h0000, ctrlLimLl);
        i_cpu.mode(1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        chk1(1'b1, modeStateInput);
        chkRd(8'h02, 16'h0001);
        i_cpu.mode(1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        chk1(1'b1, operating);
        i_cpu.wr(8'h10, 16'h0000);
        @(posedge core_clk);
        #1;
        chk1(1'b0, operating);
        for (i = 0; i < 3; i = i + 1) begin
            dorst(4'h1, 2'h0, 2'h0, (i == 0) ? 4'h2 : 4'h1,
                  (i == 1) ? 2'h1 : 2'h0, (i == 2) ? 2'h1 : 2'h0);
            chkRd(8'h00, 16'h000e | (16'h0010 << i));
            chkRd(8'h02, 16'h0002);
            i_cpu.wr(8'h27, 16'h1234);
            chkRd(8'h27, 16'h0000);
            chkRd(8'h24, 16'h001e);
            i_cpu.wr(8'h03, 16'h0000);
            chkRd(8'h02, 16'h0000);
            i_cpu.wr(8'h27, 16'h1234);
            chkRd(8'h27, 16'h1234);
        end
        dorst(4'h6, 2'h0, 2'h0, 4'h6, 2'h0, 2'h0);
        chkRd(8'h00, 16'h000f);
        chk1(1'b0, runLed);
        chk1(1'b1, errLed);
        chkRd(8'h02, 16'h0004);
        i_cpu.mode(1'b1);
        i_cpu.wr(8'h01, 16'h0000);
        chk1(1'b0, operating);
        chkRd(8'h00, 16'h000f);
        i_cpu.wr(8'h10, 16'h0001);
        chkRd(8'h10, 16'h0000);
        conclude;
    end
endmodule
